// ===== logic/sec_pkg.sv
// Shared constants and types for the security-mode controller and its host end
package sec_pkg;
	localparam logic [7:0] CMD_CTRL_LO   = 8'h00;
	localparam logic [7:0] CMD_CTRL_HI   = 8'h01;
	localparam logic [7:0] CMD_FLASH_CLS = 8'h3e;
	localparam logic [7:0] CMD_FLASH_BLK = 8'h3f;
	localparam int         KEY_W         = 16;
	localparam int         MFG_BYTES     = 32;
	localparam logic [15:0] UNSEAL_KEY1_RST = 16'h3672;
	localparam logic [15:0] UNSEAL_KEY0_RST = 16'h0414;
	localparam logic [15:0] FULL_KEY1_RST   = 16'hffff;
	localparam logic [15:0] FULL_KEY0_RST   = 16'hfffe;
	// Key slots in the key store
	localparam logic [1:0] KSLOT_UNSEAL1 = 2'h0;
	localparam logic [1:0] KSLOT_UNSEAL0 = 2'h1;
	localparam logic [1:0] KSLOT_FULL1   = 2'h2;
	localparam logic [1:0] KSLOT_FULL0   = 2'h3;
	// Host register map on Wishbone
	localparam logic [3:0] WB_CMD    = 4'h0;
	localparam logic [3:0] WB_STATUS = 4'h4;
	localparam logic [3:0] WB_RDATA  = 4'h8;
	localparam logic [3:0] WB_LEVEL  = 4'hc;
	// Host command register fields
	localparam int CMD_CODE_LSB = 16;
	localparam int CMD_WR_BIT   = 24;
	localparam int CMD_KSTORE_BIT = 25;
	localparam int CMD_KSLOT_LSB  = 26;
	typedef enum logic [1:0] {
		LVL_FULL     = 2'b00,
		LVL_UNSEALED = 2'b01,
		LVL_SEALED   = 2'b10
	} level_t;
	// Operation kinds carried on the link
	typedef enum logic [1:0] {
		OP_CMD_WR = 2'b00,
		OP_CMD_RD = 2'b01,
		OP_KEY_WR = 2'b10,
		OP_KEY_RD = 2'b11
	} op_t;
	// Control-register key words are byte-reversed compared with how stored keys read back
	function automatic logic [15:0] swap_bytes(input logic [15:0] v);
		swap_bytes = {v[7:0], v[15:8]};
	endfunction : swap_bytes
endpackage : sec_pkg

// ===== logic/sec_link_if.sv
// Command link between host controller and security-mode device
`timescale 1ns/1ps
interface sec_link_if;
	import sec_pkg::*;
	logic        req;
	op_t         op;
	logic [7:0]  code;
	logic [15:0] wdata;
	logic [1:0]  kslot;
	logic        ack;
	logic        err;
	logic [15:0] rdata;
	modport dev  (input req, op, code, wdata, kslot, output ack, err, rdata);
	modport host (output req, op, code, wdata, kslot, input ack, err, rdata);
endinterface : sec_link_if

// ===== logic/key_matcher.sv
// Two-step key sequence matcher for one key pair
`timescale 1ns/1ps
module key_matcher
	import sec_pkg::*;
#(
	parameter int W = KEY_W
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         wr_i,
	input  wire logic [W-1:0] word_i,
	input  wire logic [W-1:0] key1_i,
	input  wire logic [W-1:0] key0_i,
	output logic              match_o
);
	logic  armed;
	wire   first_ok = word_i == swap_bytes(key1_i);
	wire   second_ok = word_i == swap_bytes(key0_i);

	// Any other word in between drops the half-finished sequence
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed <= 1'b0;
		end else if (wr_i) begin
			armed <= first_ok && !(armed && second_ok);
		end
	end

	assign match_o = wr_i && armed && second_ok;
endmodule : key_matcher

// ===== logic/sec_device.sv
// Device end: security level, key store and flash access gating
`timescale 1ns/1ps
module sec_device
	import sec_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	sec_link_if.dev    link,
	output level_t     level_o,
	output logic       sealed_flag_o,
	output logic       full_access_flag_o,
	output logic       flash_rw_o,
	output logic       mfg_wr_o,
	output logic [7:0] flash_class_select_o,
	output logic [7:0] flash_block_select_o
);
	level_t      level;
	level_t      next_level;
	logic [15:0] keys [4];
	logic [15:0] rdata;
	logic        ack;
	logic        err;

	wire is_ctrl   = link.code == CMD_CTRL_LO || link.code == CMD_CTRL_HI;
	wire is_flash  = link.code == CMD_FLASH_CLS || link.code == CMD_FLASH_BLK;
	wire sealed    = level == LVL_SEALED;
	wire new_req   = link.req && !ack;
	wire ctrl_wr   = new_req && link.op == OP_CMD_WR && is_ctrl;
	wire flash_bad = new_req && is_flash && sealed;
	wire key_wr_ok = level == LVL_FULL;
	wire key_bad   = new_req && link.op == OP_KEY_WR && !key_wr_ok;
	wire req_err   = flash_bad || key_bad;
	wire unseal_hit;
	wire full_hit;

	key_matcher u_unseal (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.wr_i    (ctrl_wr),
		.word_i  (link.wdata),
		.key1_i  (keys[KSLOT_UNSEAL1]),
		.key0_i  (keys[KSLOT_UNSEAL0]),
		.match_o (unseal_hit)
	);

	key_matcher u_full (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.wr_i    (ctrl_wr),
		.word_i  (link.wdata),
		.key1_i  (keys[KSLOT_FULL1]),
		.key0_i  (keys[KSLOT_FULL0]),
		.match_o (full_hit)
	);

	// Full key only counts once unsealed; a sealed part must unseal first
	always_comb begin
		next_level = level;
		if (unseal_hit && sealed) begin
			next_level = LVL_UNSEALED;
		end else if (full_hit && level == LVL_UNSEALED) begin
			next_level = LVL_FULL;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level <= LVL_SEALED;
		end else begin
			level <= next_level;
		end
	end

	// Key store stands in for the non-volatile copies
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			keys[KSLOT_UNSEAL1] <= UNSEAL_KEY1_RST;
			keys[KSLOT_UNSEAL0] <= UNSEAL_KEY0_RST;
			keys[KSLOT_FULL1]   <= FULL_KEY1_RST;
			keys[KSLOT_FULL0]   <= FULL_KEY0_RST;
		end else if (new_req && link.op == OP_KEY_WR && key_wr_ok) begin
			keys[link.kslot] <= link.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_class_select_o <= 8'h00;
			flash_block_select_o <= 8'h00;
		end else if (new_req && link.op == OP_CMD_WR && !req_err) begin
			if (link.code == CMD_FLASH_CLS) begin
				flash_class_select_o <= link.wdata[7:0];
			end
			if (link.code == CMD_FLASH_BLK) begin
				flash_block_select_o <= link.wdata[7:0];
			end
		end
	end

	// One-cycle answer; ack drops the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack   <= 1'b0;
			err   <= 1'b0;
			rdata <= 16'h0000;
		end else begin
			ack <= new_req;
			err <= new_req && req_err;
			if (new_req) begin
				case (link.op)
					OP_KEY_RD: rdata <= keys[link.kslot];
					OP_CMD_RD: rdata <= is_ctrl ? {14'h0000, sealed, level != LVL_FULL} :
						{8'h00, link.code == CMD_FLASH_CLS ? flash_class_select_o : flash_block_select_o};
					default:   rdata <= 16'h0000;
				endcase
			end
		end
	end

	assign link.ack           = ack;
	assign link.err           = err;
	assign link.rdata         = rdata;
	assign level_o            = level;
	assign sealed_flag_o      = sealed;
	assign full_access_flag_o = level != LVL_FULL;
	assign flash_rw_o         = !sealed;
	assign mfg_wr_o           = !sealed;
endmodule : sec_device

// ===== logic/sec_host.sv
// Host end: Wishbone-controlled issuer of link commands
`timescale 1ns/1ps
module sec_host
	import sec_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	sec_link_if.host         link
);
	logic        req;
	op_t         op;
	logic [7:0]  code;
	logic [15:0] wdata;
	logic [1:0]  kslot;
	logic [15:0] rdata;
	logic        last_err;
	logic        ack;

	wire acc     = cyc_i && stb_i && !ack;
	wire cmd_go  = acc && we_i && adr_i == WB_CMD && &sel_i && !req;
	wire is_key  = dat_i[CMD_KSTORE_BIT];
	wire is_wr   = dat_i[CMD_WR_BIT];
	wire op_t    next_op = op_t'({is_key, !is_wr});

	// Keys go out as given; software must keep pairs adjacent
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req      <= 1'b0;
			op       <= OP_CMD_WR;
			code     <= 8'h00;
			wdata    <= 16'h0000;
			kslot    <= 2'h0;
			rdata    <= 16'h0000;
			last_err <= 1'b0;
		end else if (cmd_go) begin
			req   <= 1'b1;
			op    <= next_op;
			code  <= dat_i[CMD_CODE_LSB +: 8];
			wdata <= dat_i[15:0];
			kslot <= dat_i[CMD_KSLOT_LSB +: 2];
		end else if (req && link.ack) begin
			req      <= 1'b0;
			rdata    <= link.rdata;
			last_err <= link.err;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack   <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack <= acc;
			case (adr_i)
				WB_STATUS: dat_o <= {30'h00000000, last_err, req};
				WB_RDATA:  dat_o <= {16'h0000, rdata};
				default:   dat_o <= 32'h00000000;
			endcase
		end
	end

	assign ack_o      = ack;
	assign link.req   = req;
	assign link.op    = op;
	assign link.code  = code;
	assign link.wdata = wdata;
	assign link.kslot = kslot;
endmodule : sec_host

// ===== tb/sec_link_assertions.sv
// Link protocol checker for the security-mode controller
`timescale 1ns/1ps
module sec_link_assertions
	import sec_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        req,
	input wire op_t         op,
	input wire logic [7:0]  code,
	input wire logic [15:0] wdata,
	input wire logic        ack,
	input wire logic        err,
	input wire logic [15:0] rdata
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_cause; ack |-> $past(req) && !$past(ack); endproperty
	a_cause: assert property (p_cause) else $error("ack without request");
	property p_answer; req && !ack |=> ack; endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_pulse; ack |=> !ack; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_err; err |-> ack; endproperty
	a_err: assert property (p_err) else $error("err without ack");
	property p_hold; req && !ack |=> $stable(op) && $stable(code) && $stable(wdata); endproperty
	a_hold: assert property (p_hold) else $error("request changed");
	property p_drop; ack |=> !req; endproperty
	a_drop: assert property (p_drop) else $error("request kept");
	property p_ctrl; ack && op == OP_CMD_WR && code <= CMD_CTRL_HI |-> !err; endproperty
	a_ctrl: assert property (p_ctrl) else $error("control write refused");
	property p_stat; ack && op == OP_CMD_RD && code <= CMD_CTRL_HI |-> !(rdata[1] && !rdata[0]); endproperty
	a_stat: assert property (p_stat) else $error("bad status flags");
	property p_stand; !ack && !$past(rst_i) |-> $stable(rdata); endproperty
	a_stand: assert property (p_stand) else $error("reply changed");
	c_refused: cover property (ack && err && op == OP_KEY_WR);
	c_taken: cover property (ack && !err && op == OP_KEY_WR);
	c_read: cover property (ack && op == OP_CMD_RD);
endmodule : sec_link_assertions

// ===== tb/tb_security_mode_key_access.sv
// Bench for host and device ends with a reference model
`timescale 1ns/1ps
module tb_security_mode_key_access import sec_pkg::*;;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	level_t      level_o;
	logic        sf, ff, rw, mw;
	logic [7:0]  cs, bs, cls, blk;
	logic [15:0] key [4];
	logic [15:0] prev;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          lv;
	sec_link_if link_bus();
	sec_host sec_host_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr),
		.sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .link(link_bus));
	sec_device sec_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_bus), .level_o(level_o),
		.sealed_flag_o(sf), .full_access_flag_o(ff), .flash_rw_o(rw), .mfg_wr_o(mw),
		.flash_class_select_o(cs), .flash_block_select_o(bs));
	sec_link_assertions sec_link_assertions_inst (.clk_i(clk_i), .rst_i(rst_i), .req(link_bus.req),
		.op(link_bus.op), .code(link_bus.code), .wdata(link_bus.wdata), .ack(link_bus.ack),
		.err(link_bus.err), .rdata(link_bus.rdata));
	function automatic logic [15:0] sw(input logic [15:0] v);
		sw = {v[7:0], v[15:8]};
	endfunction : sw
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Request held until ack is sampled, then released for a cycle
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
	endtask : wb
	task run(input op_t o, input logic [7:0] c, input logic [15:0] d, input logic [1:0] s);
		logic [31:0] q;
		logic        e;
		logic [15:0] r;
		e = 1'b0;
		r = key[s];
		if (o == OP_CMD_RD) r = {14'h0, lv == 2, lv != 0};
		if (o == OP_KEY_WR) e = (lv != 0);
		if (o == OP_KEY_WR && !e) key[s] = d;
		if (o == OP_CMD_WR && c > CMD_CTRL_HI) e = (lv == 2);
		if (o == OP_CMD_WR && c == CMD_FLASH_CLS && !e) cls = d[7:0];
		if (o == OP_CMD_WR && c == CMD_FLASH_BLK && !e) blk = d[7:0];
		if (o == OP_CMD_WR && c <= CMD_CTRL_HI) begin
			if (lv == 2 && prev == sw(key[0]) && d == sw(key[1])) lv = 1;
			else if (lv == 1 && prev == sw(key[2]) && d == sw(key[3])) lv = 0;
			prev = d;
		end
		wb(1'b1, WB_CMD, {4'h0, s, o[1], ~o[0], c, d}, q);
		do wb(1'b0, WB_STATUS, 32'h0, q); while (q[0] === 1'b1);
		chk("err", {15'h0, q[1]}, {15'h0, e});
		if (o[0]) wb(1'b0, WB_RDATA, 32'h0, q);
		if (o[0]) chk("rdata", q[15:0], r);
		chk("level", {14'h0, level_o}, {14'h0, lv[1:0]});
		chk("flags", {sf, ff, rw, mw}, {lv == 2, lv != 0, lv != 2, lv != 2});
		chk("select", {cs, bs}, {cls, blk});
	endtask : run
	task pass(input string nm);
		int i;
		for (i = 0; i < 4; i++) begin
			run(OP_KEY_RD, CMD_CTRL_LO, 16'h0, i[1:0]);
			run(OP_KEY_WR, CMD_CTRL_LO, 16'($urandom), i[1:0]);
			run(OP_CMD_WR, CMD_FLASH_CLS + i[7:0] % 2, 16'($urandom), 2'h0);
		end
		run(OP_CMD_RD, CMD_CTRL_HI, 16'h0, 2'h0);
		$display("%s test done", nm);
	endtask : pass
	initial forever #50 clk_i = ~clk_i;
	initial begin
		repeat (30000) @(posedge clk_i);
		n_mismatch++;
		stop_test();
	end
	initial begin
		logic [31:0] q;
		void'($urandom(32'h6597));
		key = '{UNSEAL_KEY1_RST, UNSEAL_KEY0_RST, FULL_KEY1_RST, FULL_KEY0_RST};
		lv = 2;
		prev = 16'h0;
		cls = 8'h0;
		blk = 8'h0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		pass("sealed");
		run(OP_CMD_WR, CMD_CTRL_LO, key[0], 2'h0);
		run(OP_CMD_WR, CMD_CTRL_LO, key[1], 2'h0);
		run(OP_CMD_WR, CMD_CTRL_LO, sw(key[1]), 2'h0);
		run(OP_CMD_WR, CMD_CTRL_LO, sw(key[0]), 2'h0);
		run(OP_CMD_WR, CMD_CTRL_LO, 16'($urandom), 2'h0);
		run(OP_CMD_WR, CMD_CTRL_LO, sw(key[1]), 2'h0);
		run(OP_CMD_WR, CMD_CTRL_HI, sw(key[0]), 2'h0);
		run(OP_CMD_WR, CMD_CTRL_HI, sw(key[1]), 2'h0);
		pass("unsealed");
		run(OP_CMD_WR, CMD_CTRL_LO, sw(key[2]), 2'h0);
		run(OP_CMD_WR, CMD_CTRL_LO, sw(key[3]), 2'h0);
		pass("full");
		wb(1'b0, WB_LEVEL, 32'h0, q);
		chk("unmapped", q[15:0], 16'h0);
		stop_test();
	end
endmodule : tb_security_mode_key_access
